// [src/mmp_defs.vh]
// Constants for the memory map and start-up logic of the 4-bit core
`ifndef MMP_DEFS_VH
`define MMP_DEFS_VH

`define MMP_RAM_PAGE_NIBBLES   48
`define MMP_RAM_PAGES          2
`define MMP_RAM_LO             6'h10
`define MMP_RAM_HI             6'h3F
`define MMP_CTRL_BASE          6'h00
`define MMP_CTRL_NIBBLES       14
`define MMP_PAGE_RESET         1'h0
`define MMP_ROM_ADDR_W         14
`define MMP_ROM_DATA_W         10
`define MMP_ROM_RSVD_BASE      14'h3F00
`define MMP_CLK_HZ             100000000
`define MMP_INSTR_HZ           400000
`define MMP_INSTR_DIV          (`MMP_CLK_HZ / `MMP_INSTR_HZ)
`define MMP_POR_MS             131
`define MMP_POR_CYCLES         (`MMP_POR_MS * (`MMP_CLK_HZ / 1000))

`endif

// [src/mmp_ram.v]
// Nibble RAM with registered read data
`timescale 1ns/1ps
`default_nettype none
module mmp_ram #(
   parameter AW    = 7,
   parameter DEPTH = 96
) (
   input  wire          clk,     // System clock
   input  wire          wr_en,   // Write strobe
   input  wire [AW-1:0] addr,    // Physical nibble address
   input  wire [3:0]    wr_data, // Write nibble
   output reg  [3:0]    rd_data  // Registered read nibble
);
   reg [3:0] mem [0:DEPTH-1];

   always @(posedge clk) begin
      if (wr_en) begin
         mem[addr] <= wr_data;
      end
      rd_data <= mem[addr];
   end
endmodule
`default_nettype wire

// [src/mmp_core.v]
// RAM paging, control space, ROM addressing and power-on hold for the 4-bit core
// Notes on behaviour
// R1: Two pages of 48 nibbles each
// R2: Page select is zero after reset
// R3: Page changes only by page-move instruction
// R4: RAM decodes 0x10..0x3F using selected page
// R5: Fourteen-nibble system control space exists
// R6: Jump and call carry 14-bit address
// R7: Program and LED data share one ROM
// R8: Users keep out of reserved ROM region
// R9: Hold reset about 131 ms after power-up
// R10: Instructions step at 400 kHz
// R11: Out-of-window writes leave RAM untouched
`timescale 1ns/1ps
`default_nettype none
`include "mmp_defs.vh"
module mmp_core #(
   parameter POR_CYCLES = `MMP_POR_CYCLES, // Power-on hold length in clk cycles
   parameter PAGES      = `MMP_RAM_PAGES   // 1 on small parts, 2 on large
) (
   input  wire                       clk,          // 100 MHz system clock
   input  wire                       rst_b,        // Power-on reset, active low
   input  wire                       data_wr,      // Data write request
   input  wire                       data_rd,      // Data read request
   input  wire [5:0]                 data_addr,    // Data address
   input  wire [3:0]                 data_wdata,   // Data write nibble
   input  wire                       page_move,    // Page-move instruction strobe
   input  wire                       page_value,   // Page carried by page move
   input  wire                       jump_load,    // Jump or call strobe
   input  wire [`MMP_ROM_ADDR_W-1:0] jump_target,  // Jump or call word address
   input  wire                       pc_step,      // Advance program counter
   input  wire [`MMP_ROM_ADDR_W-1:0] led_addr,     // LED data fetch address
   input  wire                       led_fetch,    // LED data fetch request
   output reg  [3:0]                 data_rdata,   // Read nibble
   output reg                        data_rvalid,  // Read data valid pulse
   output reg                        ram_page_select, // Current RAM page
   output reg  [`MMP_ROM_ADDR_W-1:0] rom_addr,     // Shared ROM word address
   output reg                        rom_is_led,   // ROM cycle is LED data fetch
   output reg                        instr_tick,   // 400 kHz instruction pulse
   output reg                        core_run,     // Normal execution enabled
   output reg  [`MMP_ROM_ADDR_W-1:0] pc            // Program counter
);
   localparam DIV_W = 8;
   localparam POR_W = 25;
   localparam integer DIV_LAST_I  = `MMP_INSTR_DIV - 1;
   localparam integer POR_LAST_I  = POR_CYCLES - 1;
   localparam integer CTRL_LAST_I = `MMP_CTRL_BASE + `MMP_CTRL_NIBBLES - 1;
   localparam integer PAGE_SIZE_I = `MMP_RAM_PAGE_NIBBLES;
   // Integer constants are cut to the counter widths on purpose
   localparam [DIV_W-1:0] DIV_LAST  = DIV_LAST_I[DIV_W-1:0];
   localparam [POR_W-1:0] POR_LAST  = POR_LAST_I[POR_W-1:0];
   localparam [5:0]       RAM_LO    = `MMP_RAM_LO;
   localparam [5:0]       RAM_HI    = `MMP_RAM_HI;
   localparam [5:0]       CTRL_LAST = CTRL_LAST_I[5:0];
   localparam [6:0]       PAGE_SIZE = PAGE_SIZE_I[6:0];

   // Each register except rd_ram_reg sits beside its next-value term
   reg  [POR_W-1:0]               por_reg;
   reg  [POR_W-1:0]               por_next;
   reg                            run_next;
   reg  [DIV_W-1:0]               div_reg;
   reg  [DIV_W-1:0]               div_next;
   reg                            tick_next;
   reg                            page_next;
   reg  [`MMP_ROM_ADDR_W-1:0]     pc_next;
   reg  [`MMP_ROM_ADDR_W-1:0]     rom_next;
   reg                            rom_led_next;
   reg                            rd_ram_reg;
   reg  [3:0]                     ctrl_q_reg;
   reg  [3:0]                     ctrl_q_next;
   reg  [3:0]                     rdata_next;
   wire                           in_ram;
   wire                           in_ctrl;
   wire [6:0]                     phys_addr;
   wire [6:0]                     ram_addr;
   wire [6:0]                     page_base;
   wire [3:0]                     ram_q;
   wire [4*`MMP_CTRL_NIBBLES-1:0] ctrl_flat;

   assign in_ram    = (data_addr >= RAM_LO) && (data_addr <= RAM_HI); // R4
   assign in_ctrl   = (data_addr <= CTRL_LAST); // R5
   assign page_base = ram_page_select ? PAGE_SIZE : 7'h00; // R1
   assign phys_addr = page_base + {1'b0, data_addr - RAM_LO}; // R4
   // Out-of-window addresses park on entry 0 so the array is never indexed past its end
   assign ram_addr  = in_ram ? phys_addr : 7'h00;

   // Writes outside both windows are dropped before reaching the array
   mmp_ram #(
      .AW    (7),
      .DEPTH (`MMP_RAM_PAGE_NIBBLES * `MMP_RAM_PAGES)
   ) u_ram (
      .clk     (clk),
      .wr_en   (data_wr && in_ram && core_run), // R11
      .addr    (ram_addr),
      .wr_data (data_wdata),
      .rd_data (ram_q)
   );

   // Power-on hold then the instruction tick
   always @* begin
      por_next  = por_reg;
      run_next  = core_run;
      div_next  = div_reg;
      tick_next = 1'b0;
      if (!core_run) begin
         if (por_reg == POR_LAST) begin
            run_next = 1'b1; // R9
         end else begin
            por_next = por_reg + 1'b1; // R9
         end
      end else if (div_reg == DIV_LAST) begin
         div_next  = {DIV_W{1'b0}};
         tick_next = 1'b1; // R10
      end else begin
         div_next = div_reg + 1'b1; // R10
      end
   end

   // The divider starts only after the hold, so the first tick lands a full period in
   always @(posedge clk) begin
      if (!rst_b) begin
         por_reg    <= {POR_W{1'b0}};
         core_run   <= 1'b0;
         div_reg    <= {DIV_W{1'b0}};
         instr_tick <= 1'b0;
      end else begin
         por_reg    <= por_next;
         core_run   <= run_next;
         div_reg    <= div_next;
         instr_tick <= tick_next;
      end
   end

   // Page select has no data address; only the page move reaches it
   // With one page fitted the move is accepted and ignored
   always @* begin
      page_next = ram_page_select;
      if (core_run && page_move && PAGES > 1) begin
         page_next = page_value; // R3
      end
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         ram_page_select <= `MMP_PAGE_RESET; // R2
      end else begin
         ram_page_select <= page_next;
      end
   end

   // Program counter and shared ROM address; a jump wins over a step in the same cycle
   always @* begin
      pc_next      = pc;
      rom_next     = pc; // R7
      rom_led_next = 1'b0;
      if (core_run && jump_load) begin
         pc_next = jump_target; // R6
      end else if (core_run && pc_step) begin
         pc_next = pc + 1'b1; // R6
      end
      // LED fetch borrows the ROM port; the full 14-bit space is one page
      if (core_run && led_fetch) begin
         rom_next     = led_addr; // R7
         rom_led_next = 1'b1;
      end
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         pc         <= {`MMP_ROM_ADDR_W{1'b0}};
         rom_addr   <= {`MMP_ROM_ADDR_W{1'b0}};
         rom_is_led <= 1'b0;
      end else begin
         pc         <= pc_next;
         rom_addr   <= rom_next;
         rom_is_led <= rom_led_next;
      end
   end

   // Control nibbles, one generate entry each, gathered in one flat word for the read mux
   genvar gi;
   generate
      for (gi = 0; gi < `MMP_CTRL_NIBBLES; gi = gi + 1) begin : g_ctrl
         reg [3:0] nib_reg;
         always @(posedge clk) begin
            if (!rst_b) begin
               nib_reg <= 4'h0;
            end else if (core_run && data_wr && data_addr == gi) begin
               nib_reg <= data_wdata; // R5
            end
         end
         assign ctrl_flat[4*gi+3:4*gi] = nib_reg;
      end
   endgenerate

   // Read answer staging; unmapped nibbles read as zero so no stale data leaks out
   always @* begin
      ctrl_q_next = 4'h0;
      if (in_ctrl) begin
         ctrl_q_next = ctrl_flat[{data_addr[3:0], 2'b00} +: 4]; // R5
      end
      rdata_next = rd_ram_reg ? ram_q : ctrl_q_reg; // R4
   end

   // Read path: RAM data is a cycle late, so the answer lands one cycle on
   // Limitation: the valid pulse leads the nibble by one cycle
   always @(posedge clk) begin
      if (!rst_b) begin
         rd_ram_reg  <= 1'b0;
         ctrl_q_reg  <= 4'h0;
         data_rvalid <= 1'b0;
         data_rdata  <= 4'h0;
      end else begin
         rd_ram_reg  <= in_ram; // R4
         ctrl_q_reg  <= ctrl_q_next; // R5
         data_rvalid <= core_run && data_rd;
         data_rdata  <= rdata_next;
      end
   end
endmodule
`default_nettype wire

// [tb/mmp_monitor.sv]
// Port assertions for the memory map and start-up core
`timescale 1ns/1ps
`default_nettype none
module mmp_monitor #(
   parameter POR_CYCLES = 20
) (
   input wire logic        clk,             // Clock
   input wire logic        rst_b,           // Reset
   input wire logic        data_rd,         // Read
   input wire logic        page_move,       // Page move
   input wire logic        page_value,      // New page
   input wire logic        jump_load,       // Jump
   input wire logic [13:0] jump_target,     // Target
   input wire logic        pc_step,         // Step
   input wire logic        data_rvalid,     // Read valid
   input wire logic        ram_page_select, // Page
   input wire logic        instr_tick,      // Tick
   input wire logic        core_run,        // Running
   input wire logic [13:0] pc               // Counter
);
   logic [31:0] cnt;
   // Cycles since reset release
   always @(posedge clk) cnt <= rst_b ? cnt + 32'h1 : 32'h0;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_prst; $rose(rst_b) |-> !ram_page_select; endproperty
   a_prst: assert property (p_prst) else $error("page not zero");
   property p_pmv; core_run && page_move |=> ram_page_select == $past(page_value); endproperty
   a_pmv: assert property (p_pmv) else $error("page move lost");
   property p_phold; !(core_run && page_move) |=> $stable(ram_page_select); endproperty
   a_phold: assert property (p_phold) else $error("page changed");
   property p_rv; data_rvalid == $past(core_run && data_rd); endproperty
   a_rv: assert property (p_rv) else $error("read valid wrong");
   property p_jmp; core_run && jump_load |=> pc == $past(jump_target); endproperty
   a_jmp: assert property (p_jmp) else $error("jump wrong");
   property p_step; core_run && pc_step && !jump_load |=> pc == $past(pc) + 14'h1; endproperty
   a_step: assert property (p_step) else $error("step wrong");
   property p_tick; instr_tick |=> !instr_tick ##249 instr_tick; endproperty
   a_tick: assert property (p_tick) else $error("tick spacing");
   property p_por; cnt < POR_CYCLES |-> !core_run; endproperty
   a_por: assert property (p_por) else $error("run too early");
   property p_run; cnt >= POR_CYCLES |-> core_run; endproperty
   a_run: assert property (p_run) else $error("run too late");
   c_page: cover property (core_run && page_move && page_value);
   c_jump: cover property (core_run && jump_load);
   c_read: cover property (data_rvalid);
endmodule
`default_nettype wire

// [tb/mmp_seq.sv]
// Instruction sequencer model issuing random jumps, steps and LED fetches
`timescale 1ns/1ps
`default_nettype none
module mmp_seq (
   input  wire logic        clk,                 // Clock
   input  wire logic        run,                 // Core running
   output var  logic        pc_step = 1'b0,      // Step
   output var  logic        jump_load = 1'b0,    // Jump
   output var  logic [13:0] jump_target = 14'h0, // Target
   output var  logic        led_fetch = 1'b0,    // LED fetch
   output var  logic [13:0] led_addr = 14'h0     // LED address
);
   always @(posedge clk) begin
      pc_step <= run && ($urandom % 2 == 0);
      jump_load <= run && ($urandom % 8 == 0);
      jump_target <= 14'($urandom % 14'h3F00);
      led_fetch <= run && ($urandom % 4 == 0);
      led_addr <= 14'($urandom % 14'h3F00);
   end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the memory map and start-up core
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam POR_CYCLES = 20;
   localparam INSTR_DIV = 250; // 100 MHz clock over the 400 kHz instruction rate
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        data_wr = 1'b0;
   logic        data_rd = 1'b0;
   logic [5:0]  data_addr = 6'h00;
   logic [3:0]  data_wdata = 4'h0;
   logic        page_move = 1'b0;
   logic        page_value = 1'b0;
   logic        pc_step, jump_load, led_fetch, data_rvalid, ram_page_select;
   logic        rom_is_led, instr_tick, core_run;
   logic [13:0] jump_target, led_addr, rom_addr, pc;
   logic [3:0]  data_rdata;
   logic [3:0]  m [0:127];
   logic        pg;
   int          fails, checks, k;
   int          por_cnt, div_cnt, exp_pc, exp_rom;
   logic        exp_run, exp_tick, exp_rv, exp_led;
   mmp_core #(.POR_CYCLES(POR_CYCLES)) u_mmp_core (.clk(clk), .rst_b(rst_b),
      .data_wr(data_wr), .data_rd(data_rd), .data_addr(data_addr), .data_wdata(data_wdata),
      .page_move(page_move), .page_value(page_value), .jump_load(jump_load),
      .jump_target(jump_target), .pc_step(pc_step), .led_addr(led_addr),
      .led_fetch(led_fetch), .data_rdata(data_rdata), .data_rvalid(data_rvalid),
      .ram_page_select(ram_page_select), .rom_addr(rom_addr), .rom_is_led(rom_is_led),
      .instr_tick(instr_tick), .core_run(core_run), .pc(pc));
   mmp_seq u_mmp_seq (.clk(clk), .run(core_run), .pc_step(pc_step), .jump_load(jump_load),
      .jump_target(jump_target), .led_fetch(led_fetch), .led_addr(led_addr));
   initial forever #5 clk = ~clk;
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   // Reference model of the hold, the tick, read valid and the ROM address
   always @(posedge clk) begin
      if (rst_b !== 1'b1) begin
         por_cnt <= 0;
         div_cnt <= 0;
         exp_pc <= 0;
         exp_rom <= 0;
         exp_run <= 1'b0;
         exp_tick <= 1'b0;
         exp_rv <= 1'b0;
         exp_led <= 1'b0;
      end else begin
         por_cnt <= exp_run ? por_cnt : por_cnt + 1;
         exp_run <= exp_run || por_cnt == POR_CYCLES - 1;
         div_cnt <= (!exp_run || div_cnt == INSTR_DIV - 1) ? 0 : div_cnt + 1;
         exp_tick <= exp_run && div_cnt == INSTR_DIV - 1;
         exp_rv <= exp_run && data_rd;
         exp_led <= exp_run && led_fetch;
         exp_rom <= (exp_run && led_fetch) ? led_addr : exp_pc;
         if (exp_run && jump_load) exp_pc <= jump_target;
         else if (exp_run && pc_step) exp_pc <= (exp_pc + 1) % 16384;
      end
   end
   // Outputs are settled at the falling edge
   always @(negedge clk) begin
      chk(core_run, exp_run);
      chk(instr_tick, exp_tick);
      chk(data_rvalid, exp_rv);
      chk(pc, exp_pc);
      chk(rom_addr, exp_rom);
      chk(rom_is_led, exp_led);
   end
   task end_of_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Address is held through the edge after the request, as the read path needs
   task op(input logic w, input logic [5:0] a, input logic [3:0] d);
      logic [6:0] i;
      i = (a < 6'h10) ? {1'b0, a} : {pg, a};
      @(posedge clk);
      data_wr <= w;
      data_rd <= !w;
      data_addr <= a;
      data_wdata <= d;
      @(posedge clk);
      data_wr <= 1'b0;
      data_rd <= 1'b0;
      if (w && a != 6'h0E && a != 6'h0F) m[i] = d;
      @(posedge clk);
      #1;
      if (!w && (a == 6'h0E || a == 6'h0F)) chk(data_rdata, 4'h0);
      else if (!w && m[i] !== 4'hx) chk(data_rdata, m[i]);
   endtask
   task pm(input logic v);
      @(posedge clk);
      page_move <= 1'b1;
      page_value <= v;
      @(posedge clk);
      page_move <= 1'b0;
      pg = v;
      #1;
      chk({3'h0, ram_page_select}, {3'h0, pg});
   endtask
   initial begin
      void'($urandom(8));
      fails = 0;
      checks = 0;
      pg = 1'b0;
      for (k = 0; k < 128; k++) m[k] = (k < 14) ? 4'h0 : 4'hx;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      for (k = 0; k < 100 && core_run !== 1'b1; k++) @(posedge clk);
      if (core_run !== 1'b1) begin
         fails++;
      end else begin
         chk({3'h0, ram_page_select}, 4'h0);
         for (k = 0; k < 600; k++) begin
            if ($urandom % 8 == 0) pm($urandom % 2);
            else op($urandom % 2, $urandom % 64, $urandom % 16);
         end
      end
      end_of_test();
   end
endmodule
bind mmp_core mmp_monitor #(.POR_CYCLES(POR_CYCLES)) u_mmp_monitor (.clk(clk),
   .rst_b(rst_b), .data_rd(data_rd), .page_move(page_move), .page_value(page_value),
   .jump_load(jump_load), .jump_target(jump_target), .pc_step(pc_step),
   .data_rvalid(data_rvalid), .ram_page_select(ram_page_select),
   .instr_tick(instr_tick), .core_run(core_run), .pc(pc));
`default_nettype wire
